//--- rtl/bitpump_consts.svh
// Purpose: Offsets, field positions, reset values and counts for the bit pump serial port.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef BITPUMP_CONSTS_SVH
`define BITPUMP_CONSTS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define AUX_CMD_ADDR       8'hF3
`define LANE_STATUS_ADDR   8'hF4
`define AUX_CMD_RESET      8'h00

// ****************************************************************
// Command register fields
// ****************************************************************
`define RX_TAP_EN_BIT      0
`define RX_AUX_SEL_BIT     1
`define ZBIT_MODE_BIT      2
`define TX_INS_EN_LSB      3
`define TX_INS_EN_MSB      5

// ****************************************************************
// Status register fields
// ****************************************************************
`define STAT_ALIGN_LSB     0
`define STAT_ALIGN_MSB     2
`define STAT_EMPTY_LSB     3
`define STAT_EMPTY_MSB     5

// ****************************************************************
// Structure and timing counts
// ****************************************************************
`define LINE_CHANNELS      3
`define SYMBOL_BITS        2
`define SYM_FIFO_DEPTH     32
`define PIN_SYNC_WIDTH     4
`define PAYLOAD_BYTE_BITS  4'h8

`endif

//--- rtl/bitpump_pkg.sv
// Purpose: Types shared by the bit pump serial port modules.
// Assumes: Nothing beyond the standard language.
// Notes:   Constants live in bitpump_consts.svh.
package bitpump_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_BYTE = 3'b010,
    ST_ZBIT = 3'b100
  } strobe_state_t;

  typedef logic [1:0] dibit_t;

endpackage

//--- rtl/hdsl_bitpump_serial_port.sv
// Purpose: Serial port between the channel unit and three 2B1Q bit pumps.
// Assumes: Bit clocks run well below mclk_i and are sampled as ordinary pins.
// Notes:   Each lane finds bit clock edges from its filtered pin level.
//
// Functional notes
// - Three independent lanes, each with own clocks, data and auxiliary signals.
// - Transmit data, strobe, tap and overhead flag change on bit clock rise.
// - Phase clock, receive data and aux input sampled on bit clock fall.
// - Phase clock sampled 0 means sign slot, 1 means magnitude slot.
// - Transmit sign while phase clock low, magnitude while high.
// - Receive sign captured with phase low, magnitude with phase high.
// - Aux input taken only on falls while the insert strobe is high.
// - Sampled aux bits replace normal bits at the scrambler input.
// - Strobe high 8 bit times per selected byte, 1 per Z-bit.
// - Insertion marks either last 40 Z-bits or chosen payload bytes.
// - Descrambler output presented on tap output every bit clock rise.
// - Tap outputs share pins with drop, insert, master sync; enable selects.
// - Select 0: overhead flag marks bits written into receive store.
// - Select 1: overhead flag marks last 40 Z-bits of frame.
// - Reset clears all insert and tap enable bits.
`timescale 1ns/1ps
`include "bitpump_consts.svh"
module hdsl_bitpump_serial_port
  import bitpump_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             reset_n_i,
  input  wire logic [2:0]       bclk_i,
  input  wire logic [2:0]       symbol_phase_clock_i,
  input  wire logic [2:0]       line_rx_serial_i,
  input  wire logic [2:0]       aux_insert_input_i,
  output logic      [2:0]       line_tx_serial_o,
  output logic      [2:0]       aux_insert_strobe_o,
  output logic      [2:0]       descrambled_tap_output_o,
  output logic      [2:0]       rx_overhead_flag_o,
  input  wire logic             shared_drop_i,
  input  wire logic             shared_insert_i,
  input  wire logic             shared_master_frame_sync_i,
  output logic      [2:0]       shared_pin_o,
  input  wire logic [2:0][1:0]  tx_dibit_i,
  input  wire logic [2:0]       tx_dibit_valid_i,
  output logic      [2:0]       tx_dibit_ready_o,
  output logic      [2:0][1:0]  rx_dibit_o,
  output logic      [2:0]       rx_dibit_valid_o,
  input  wire logic [2:0]       tx_pcm_bit_i,
  output logic      [2:0]       scr_in_bit_o,
  output logic      [2:0]       scr_in_valid_o,
  input  wire logic [2:0]       tx_byte_start_i,
  input  wire logic [2:0]       tx_byte_select_i,
  input  wire logic [2:0]       tx_last40_zbit_i,
  input  wire logic [2:0]       rx_descrambled_bit_i,
  input  wire logic [2:0]       rx_fifo_write_i,
  input  wire logic [2:0]       rx_last40_zbit_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_wr_i,
  output logic      [7:0]       reg_rdata_o
);

  // ****************************************************************
  // Command and status registers
  // ****************************************************************
  logic [7:0] aux_output_command;
  logic [2:0] lane_aligned;
  logic [2:0] lane_empty;
  logic       cmd_hit;
  logic       stat_hit;
  logic [7:0] status_word;
  logic [7:0] next_rdata;
  logic       rx_tap_enable;
  logic       rx_aux_select;
  logic       zbit_mode;
  logic [2:0] tx_insert_enable;

  assign cmd_hit          = (reg_addr_i == `AUX_CMD_ADDR);
  assign stat_hit         = (reg_addr_i == `LANE_STATUS_ADDR);
  assign rx_tap_enable    = aux_output_command[`RX_TAP_EN_BIT];
  assign rx_aux_select    = aux_output_command[`RX_AUX_SEL_BIT];
  assign zbit_mode        = aux_output_command[`ZBIT_MODE_BIT];
  assign tx_insert_enable = aux_output_command[`TX_INS_EN_MSB:`TX_INS_EN_LSB];
  assign status_word      = {2'h0, lane_empty, lane_aligned};
  assign next_rdata       = cmd_hit ? aux_output_command :
                            stat_hit ? status_word : 8'h00;

  // Reset empties every enable so no lane inserts or taps until software asks.
  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      aux_output_command <= `AUX_CMD_RESET;
      reg_rdata_o        <= 8'h00;
    end
    else
    begin
      if (reg_wr_i && cmd_hit)
      begin
        aux_output_command <= reg_wdata_i;
      end
      reg_rdata_o <= next_rdata;
    end
  end

  // ****************************************************************
  // Shared pins
  // ****************************************************************
  // Lane 1 sits on the drop pin, lane 2 on insert, lane 3 on master sync.
  assign shared_pin_o[0] = rx_tap_enable ? descrambled_tap_output_o[0] : shared_drop_i;
  assign shared_pin_o[1] = rx_tap_enable ? descrambled_tap_output_o[1] : shared_insert_i;
  assign shared_pin_o[2] = rx_tap_enable ? descrambled_tap_output_o[2] : shared_master_frame_sync_i;

  // ****************************************************************
  // Line lanes
  // ****************************************************************
  for (genvar ch = 0; ch < `LINE_CHANNELS; ch++)
  begin : g_lane
    logic [3:0]    pin_level;
    logic          bclk_s;
    logic          symbol_phase_clock_s;
    logic          line_rx_serial_s;
    logic          aux_s;
    logic          bclk_prev;
    logic          rise_evt;
    logic          fall_evt;
    logic          symbol_phase_clock_last;
    logic          aligned;
    logic          tx_bit;
    logic          mag_hold;
    logic          sign_hold;
    logic          have_sign;
    dibit_t        rx_pair;
    logic          rx_pulse;
    logic          tap_bit;
    logic          ovh_bit;
    logic          scr_bit;
    logic          scr_pulse;
    strobe_state_t st;
    strobe_state_t next_st;
    strobe_state_t launch_st;
    logic [3:0]    cnt;
    logic [3:0]    next_cnt;
    logic [3:0]    launch_cnt;
    logic          start_byte;
    logic          start_z;
    logic          strobe_on;
    logic          sym_start;
    dibit_t        sym_now;

    sym_if u_sym ();

    pin_sync #(.WIDTH(`PIN_SYNC_WIDTH)) u_sync
    (
      .mclk_i    (mclk_i),
      .reset_n_i (reset_n_i),
      .pin_i     ({aux_insert_input_i[ch], line_rx_serial_i[ch],
                   symbol_phase_clock_i[ch], bclk_i[ch]}),
      .level_o   (pin_level)
    );

    sym_fifo #(.WIDTH(`SYMBOL_BITS), .DEPTH(`SYM_FIFO_DEPTH)) u_fifo
    (
      .mclk_i     (mclk_i),
      .reset_n_i  (reset_n_i),
      .in_valid_i (tx_dibit_valid_i[ch]),
      .in_ready_o (tx_dibit_ready_o[ch]),
      .in_data_i  (tx_dibit_i[ch]),
      .out        (u_sym.source)
    );

    assign bclk_s   = pin_level[0];
    assign symbol_phase_clock_s   = pin_level[1];
    assign line_rx_serial_s   = pin_level[2];
    assign aux_s    = pin_level[3];
    assign rise_evt = bclk_s & ~bclk_prev;
    assign fall_evt = ~bclk_s & bclk_prev;

    // The next slot is a new symbol when the last sample showed magnitude.
    assign sym_start   = rise_evt & symbol_phase_clock_last;
    assign u_sym.ready = sym_start;
    assign sym_now     = u_sym.valid ? u_sym.data : 2'h0;

    // Insert strobe sequencing.
    assign start_byte = ~zbit_mode & tx_insert_enable[ch] &
                        tx_byte_start_i[ch] & tx_byte_select_i[ch];
    assign start_z    = zbit_mode & tx_insert_enable[ch] & tx_last40_zbit_i[ch];
    assign launch_st  = start_byte ? ST_BYTE : (start_z ? ST_ZBIT : ST_IDLE);
    assign launch_cnt = start_byte ? (`PAYLOAD_BYTE_BITS - 4'h1) : 4'h0;
    assign strobe_on  = (st != ST_IDLE);

    always_comb
    begin
      next_st  = launch_st;
      next_cnt = launch_cnt;
      unique case (st)
        ST_IDLE, ST_ZBIT:
        begin
          next_st  = launch_st;
          next_cnt = launch_cnt;
        end
        ST_BYTE:
        begin
          if (cnt != 4'h0)
          begin
            next_st  = ST_BYTE;
            next_cnt = cnt - 4'h1;
          end
        end
      endcase
      if (!tx_insert_enable[ch])
      begin
        next_st  = ST_IDLE;
        next_cnt = 4'h0;
      end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        bclk_prev <= 1'b0;
        symbol_phase_clock_last <= 1'b1;
        aligned   <= 1'b0;
        tx_bit    <= 1'b0;
        mag_hold  <= 1'b0;
        st        <= ST_IDLE;
        cnt       <= 4'h0;
        tap_bit   <= 1'b0;
        ovh_bit   <= 1'b0;
      end
      else
      begin
        bclk_prev <= bclk_s;
        if (rise_evt)
        begin
          st      <= next_st;
          cnt     <= next_cnt;
          tap_bit <= rx_descrambled_bit_i[ch];
          ovh_bit <= rx_aux_select ? rx_last40_zbit_i[ch] : rx_fifo_write_i[ch];
          if (symbol_phase_clock_last)
          begin
            tx_bit   <= sym_now[1];
            mag_hold <= sym_now[0];
          end
          else
          begin
            tx_bit <= mag_hold;
          end
        end
        if (fall_evt)
        begin
          symbol_phase_clock_last <= symbol_phase_clock_s;
          aligned   <= (symbol_phase_clock_s != symbol_phase_clock_last);
        end
      end
    end

    // Receive pairing and scrambler-input substitution, both on the falling edge.
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
      if (!reset_n_i)
      begin
        sign_hold <= 1'b0;
        have_sign <= 1'b0;
        rx_pair   <= 2'h0;
        rx_pulse  <= 1'b0;
        scr_bit   <= 1'b0;
        scr_pulse <= 1'b0;
      end
      else
      begin
        rx_pulse  <= 1'b0;
        scr_pulse <= fall_evt;
        if (fall_evt)
        begin
          scr_bit <= strobe_on ? aux_s : tx_pcm_bit_i[ch];
          if (!symbol_phase_clock_s)
          begin
            sign_hold <= line_rx_serial_s;
            have_sign <= 1'b1;
          end
          else if (have_sign)
          begin
            rx_pair   <= {sign_hold, line_rx_serial_s};
            rx_pulse  <= 1'b1;
            have_sign <= 1'b0;
          end
        end
      end
    end

    assign line_tx_serial_o[ch]         = tx_bit;
    assign aux_insert_strobe_o[ch]      = strobe_on;
    assign descrambled_tap_output_o[ch] = tap_bit;
    assign rx_overhead_flag_o[ch]       = ovh_bit;
    assign rx_dibit_o[ch]               = rx_pair;
    assign rx_dibit_valid_o[ch]         = rx_pulse;
    assign scr_in_bit_o[ch]             = scr_bit;
    assign scr_in_valid_o[ch]           = scr_pulse;
    assign lane_aligned[ch]             = aligned;
    assign lane_empty[ch]               = ~u_sym.valid;
  end

endmodule

//--- rtl/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to mclk_i.
// Notes:   The filtered value moves only when stages two and three agree.
`timescale 1ns/1ps
module pin_sync
#(
  parameter int WIDTH = 4
)
(
  input  wire logic             mclk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stage1  <= '0;
      stage2  <= '0;
      stage3  <= '0;
      level_o <= '0;
    end
    else
    begin
      stage1  <= pin_i;
      stage2  <= stage1;
      stage3  <= stage2;
      level_o <= (stage2 & stage3) | (level_o & (stage2 | stage3));
    end
  end

endmodule

//--- rtl/sym_fifo.sv
// Purpose: Synchronous FIFO for transmit symbols, flip-flop storage.
// Assumes: Single clock domain.
// Notes:   in_ready_o falls when full, so the writer is held off.
`timescale 1ns/1ps
module sym_fifo
#(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
)
(
  input  wire logic             mclk_i,
  input  wire logic             reset_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  sym_if.source                 out
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    ptr_step = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready_o = (count != (PW+1)'(DEPTH));
  assign out.valid  = (count != '0);
  assign out.data   = store[rd_ptr];
  assign push       = in_valid_i & in_ready_o;
  assign pop        = out.valid & out.ready;

  always_ff @(posedge mclk_i)
  begin
    if (push)
    begin
      store[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= ptr_step(wr_ptr);
      end
      if (pop)
      begin
        rd_ptr <= ptr_step(rd_ptr);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

//--- rtl/sym_if.sv
// Purpose: Carrier for transmit symbols between the symbol FIFO and a line lane.
// Assumes: Both ends run on the same clock.
// Notes:   A symbol moves when valid and ready are both high.
`timescale 1ns/1ps
interface sym_if;
  logic       valid;
  logic       ready;
  logic [1:0] data;

  modport source
  (
    output valid,
    output data,
    input  ready
  );

  modport sink
  (
    input  valid,
    input  data,
    output ready
  );
endinterface

//--- testbench/bitpump_line_model.sv
// Purpose: Behavioural line transceiver for one lane.
// Assumes: Bit period 200 ns; symbols sent whole.
// Notes:   Clock stands still while run_i is low.
`timescale 1ns/1ps
module bitpump_line_model
#(
  parameter int START_NS = 7
)
(
  input  wire logic         run_i,
  input  wire logic         line_tx_i,
  output logic              bclk_o,
  output logic              phase_o,
  output logic              rx_o,
  output logic              drained_o,
  output logic      [127:0] got_o
);
  // ****************************************************************
  // Symbol loop
  // ****************************************************************
  int         n;
  logic [1:0] k;
  logic       s;
  initial
  begin
    {bclk_o, phase_o, rx_o, drained_o, n, k, got_o} = '0;
    #(START_NS);
    forever
    begin
      if (!run_i)
      begin
        // An idle line must not look like a held bit.
        rx_o = ~rx_o;
        wait (run_i);
      end
      bclk_o = 1'b1;
      phase_o = 1'b0;
      rx_o = k[1];
      #100 bclk_o = 1'b0;
      #99 s = line_tx_i;
      #1 bclk_o = 1'b1;
      phase_o = 1'b1;
      rx_o = k[0];
      #100 bclk_o = 1'b0;
      #99 if (n < 64) got_o[2*n +: 2] = {s, line_tx_i};
      n++;
      k++;
      drained_o = (n >= 40);
      #1;
    end
  end
endmodule

//--- testbench/bitpump_port_monitor.sv
// Purpose: Port assertions for the bit pump serial port.
// Assumes: Sees only top module ports; lane one is checked.
// Notes:   Shadow of the command register is rebuilt from writes.
`timescale 1ns/1ps
`include "bitpump_consts.svh"
module bitpump_port_monitor
(
  input wire logic       mclk_i,
  input wire logic       reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       shared_drop_i,
  input wire logic       shared_insert_i,
  input wire logic       shared_master_frame_sync_i,
  input wire logic [2:0] shared_pin_o,
  input wire logic [2:0] descrambled_tap_output_o,
  input wire logic [2:0] rx_descrambled_bit_i,
  input wire logic [2:0] aux_insert_strobe_o,
  input wire logic [2:0] scr_in_valid_o,
  input wire logic [2:0] rx_overhead_flag_o,
  input wire logic [2:0] rx_fifo_write_i,
  input wire logic [2:0] rx_last40_zbit_i,
  input wire logic [2:0] rx_dibit_valid_o
);
  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [7:0] cmd;
  always_ff @(posedge mclk_i or negedge reset_n_i)
    if (!reset_n_i)
      cmd <= `AUX_CMD_RESET;
    else if (reg_wr_i && reg_addr_i == `AUX_CMD_ADDR)
      cmd <= reg_wdata_i;
  // Counting bit slots rather than mclk cycles keeps the check free of the bit period.
  logic [3:0] slot_cnt;
  always_ff @(posedge mclk_i or negedge reset_n_i)
    if (!reset_n_i)
      slot_cnt <= 4'h0;
    else if (!aux_insert_strobe_o[0])
      slot_cnt <= 4'h0;
    else if (scr_in_valid_o[0])
      slot_cnt <= slot_cnt + 4'h1;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_strobe_down;
    $fell(aux_insert_strobe_o[0]);
  endsequence
  sequence s_flag_up;
    $rose(rx_overhead_flag_o[0]);
  endsequence
  a_cmd_read : assert property (
    reg_addr_i == `AUX_CMD_ADDR |=> reg_rdata_o == $past(cmd))
    else $error("Command read back wrong.");
  a_unmapped_zero : assert property (
    reg_addr_i != `AUX_CMD_ADDR && reg_addr_i != `LANE_STATUS_ADDR |=> reg_rdata_o == 8'h00)
    else $error("Unmapped read not zero.");
  a_shared_mux : assert property (
    shared_pin_o == (cmd[0] ? descrambled_tap_output_o
                            : {shared_master_frame_sync_i, shared_insert_i, shared_drop_i}))
    else $error("Shared pins wrong.");
  a_tap_copy : assert property (
    $changed(descrambled_tap_output_o[0]) |->
      descrambled_tap_output_o[0] == $past(rx_descrambled_bit_i[0]))
    else $error("Tap output not the descrambled bit.");
  a_byte_strobe : assert property (
    s_strobe_down ##0 !cmd[2] |-> slot_cnt == 4'h8)
    else $error("Byte strobe not eight bit slots.");
  a_zbit_strobe : assert property (
    s_strobe_down ##0 cmd[2] |-> slot_cnt == 4'h1)
    else $error("Z-bit strobe not one bit slot.");
  a_flag_fifo : assert property (
    s_flag_up ##0 !$past(cmd[1]) |-> $past(rx_fifo_write_i[0]))
    else $error("Overhead flag without store write.");
  a_flag_zbit : assert property (
    s_flag_up ##0 $past(cmd[1]) |-> $past(rx_last40_zbit_i[0]))
    else $error("Overhead flag outside last Z-bits.");
  a_rx_pulse : assert property (
    rx_dibit_valid_o[0] |=> !rx_dibit_valid_o[0] [*8])
    else $error("Receive symbols too close.");
endmodule
bind hdsl_bitpump_serial_port bitpump_port_monitor i_mon (.*);

//--- testbench/tb_hdsl_bitpump_serial_port.sv
// Purpose: Self-checking bench for the bit pump serial port.
// Assumes: 40 MHz mclk_i, three line models.
// Notes:   Marks are held for one bit time so one rise event sees them.
`timescale 1ns/1ps
module tb_hdsl_bitpump_serial_port;
  import bitpump_pkg::*;
  logic            mclk_i, reset_n_i, shared_drop_i, shared_insert_i, shared_master_frame_sync_i, reg_wr_i;
  wire  [2:0]      bclk_i, symbol_phase_clock_i, line_rx_serial_i, drained;
  logic [2:0]      aux_insert_input_i, line_tx_serial_o, aux_insert_strobe_o, tx_pcm_bit_i;
  logic [2:0]      descrambled_tap_output_o, rx_overhead_flag_o, shared_pin_o, scr_in_bit_o;
  logic [2:0]      tx_dibit_valid_i, tx_dibit_ready_o, rx_dibit_valid_o, scr_in_valid_o;
  logic [2:0]      tx_byte_start_i, tx_byte_select_i, tx_last40_zbit_i, rx_descrambled_bit_i;
  logic [2:0]      rx_fifo_write_i, rx_last40_zbit_i, have;
  logic [7:0]      reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [2:0][1:0] tx_dibit_i, rx_dibit_o;
  wire  [127:0]    got [3];
  dibit_t          prev [3];
  logic            run;
  int              n_fail, n_checks, i, ln, k0, cnt;

  hdsl_bitpump_serial_port i_dut (.*);
  for (genvar g = 0; g < 3; g++)
  begin : gen_line
    bitpump_line_model #(.START_NS(7 + 37 * g)) i_line (.run_i(run),
      .line_tx_i(line_tx_serial_o[g]), .bclk_o(bclk_i[g]), .phase_o(symbol_phase_clock_i[g]),
      .rx_o(line_rx_serial_i[g]), .drained_o(drained[g]), .got_o(got[g]));
  end
  always #12.5 mclk_i = ~mclk_i;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    @(posedge mclk_i);
    #1 chk(reg_rdata_o, e);
  endtask
  task bits(input int n);
    repeat (8 * n) @(posedge mclk_i);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Received symbols carry a counter, so each must be the last plus one.
  always @(posedge mclk_i)
  begin
    #1;
    for (int l = 0; l < 3; l++)
      if (!reset_n_i)
        have[l] = 1'b0;
      else if (rx_dibit_valid_o[l] === 1'b1)
      begin
        if (have[l])
          chk(rx_dibit_o[l], dibit_t'(prev[l] + 2'h1));
        prev[l] = rx_dibit_o[l];
        have[l] = 1'b1;
      end
  end

  initial
  begin
    #200000;
    n_fail++;
    stop_test;
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    {mclk_i, reset_n_i, run, reg_wr_i, reg_addr_i, reg_wdata_i, tx_dibit_i} = '0;
    {shared_drop_i, shared_insert_i, shared_master_frame_sync_i, tx_dibit_valid_i, tx_pcm_bit_i} = '0;
    {tx_byte_start_i, tx_last40_zbit_i, rx_descrambled_bit_i, rx_fifo_write_i} = '0;
    rx_last40_zbit_i = '0;
    aux_insert_input_i = 3'h7;
    tx_byte_select_i = 3'h7;
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd(8'hF3, 8'h00);
    wr(8'hF3, 8'hFF);
    rd(8'hF3, 8'hFF);
    rd(8'h10, 8'h00);
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rd(8'hF3, 8'h00);
    $display("test registers done");
    for (i = 0; i < 32; i++)
    begin
      @(posedge mclk_i);
      tx_dibit_valid_i <= 3'h7;
      tx_dibit_i <= {3{dibit_t'(i % 3 + 1)}};
    end
    @(posedge mclk_i);
    tx_dibit_valid_i <= 3'h0;
    #1 chk(tx_dibit_ready_o, 3'h0);
    $display("test fifo fill done");
    run <= 1'b1;
    for (i = 0; i < 4000 && drained !== 3'h7; i++)
      @(posedge mclk_i);
    chk(drained, 8'h07);
    for (ln = 0; ln < 3; ln++)
    begin
      for (k0 = 0; k0 < 8 && got[ln][2*k0 +: 2] == 2'h0; k0++);
      for (i = 0; i < 32; i++)
        chk(got[ln][2*(k0+i) +: 2], dibit_t'(i % 3 + 1));
      chk(got[ln][2*(k0+32) +: 2], 8'h00);
    end
    rd(8'hF4, 8'h3F);
    $display("test transmit done");
    // Payload byte, Z-bit, then insertion disabled.
    for (i = 0; i < 3; i++)
    begin
      wr(8'hF3, i == 0 ? 8'h08 : i == 1 ? 8'h0C : 8'h00);
      @(posedge mclk_i);
      tx_last40_zbit_i <= (i == 1) ? 3'h7 : 3'h0;
      tx_byte_start_i <= (i == 1) ? 3'h0 : 3'h7;
      cnt = 0;
      for (k0 = 0; k0 < 136; k0++)
      begin
        @(posedge mclk_i);
        if (k0 == 7)
        begin
          tx_last40_zbit_i <= 3'h0;
          tx_byte_start_i <= 3'h0;
        end
        #1 cnt += (scr_in_valid_o[0] === 1'b1 && scr_in_bit_o[0] === 1'b1);
      end
      chk(8'(cnt), i == 0 ? 8'h08 : i == 1 ? 8'h01 : 8'h00);
    end
    $display("test insert done");
    @(posedge mclk_i);
    rx_fifo_write_i <= 3'h7;
    rx_descrambled_bit_i <= 3'h5;
    shared_insert_i <= 1'b1;
    shared_master_frame_sync_i <= 1'b1;
    wr(8'hF3, 8'h01);
    bits(4);
    #1 chk(rx_overhead_flag_o, 8'h07);
    chk(descrambled_tap_output_o, 8'h05);
    chk(shared_pin_o, 8'h05);
    wr(8'hF3, 8'h02);
    bits(4);
    #1 chk(rx_overhead_flag_o, 8'h00);
    chk(shared_pin_o, 8'h06);
    @(posedge mclk_i);
    rx_last40_zbit_i <= 3'h7;
    bits(4);
    #1 chk(rx_overhead_flag_o, 8'h07);
    $display("test overhead done");
    stop_test;
  end
endmodule
